// ==== verilog/scfg_pkg.sv ====
// Purpose: Shared constants for the two-wire configuration port
// Assumes: Both ends run on one 125 MHz system clock
// Notes: Register count and defaults are set here
package scfg_pkg;
    localparam logic [7:0] SCFG_ADDR_BYTE = 8'hDC;
    localparam logic [6:0] SCFG_ADDR7 = 7'h6E;
    localparam int SCFG_CMD_MODE_BIT = 7;
    localparam logic [7:0] SCFG_CMD_BLOCK = 8'h00;
    localparam int SCFG_NREG = 3;
    localparam int SCFG_OE_REG = 1;
    localparam logic [7:0] SCFG_DEF0 = 8'h07;
    localparam logic [7:0] SCFG_DEF1 = 8'hFF;
    localparam logic [7:0] SCFG_DEF2 = 8'h00;
    // Link clock period in ns and host half period in system cycles
    localparam int SCFG_SCL_NS = 160;
    localparam int SCFG_CLK_NS = 8;
    localparam int SCFG_HALF_CYC = SCFG_SCL_NS / SCFG_CLK_NS / 2;
    localparam int SCFG_QTR_CYC = SCFG_HALF_CYC / 2;
endpackage : scfg_pkg

// ==== verilog/scfg_if.sv ====
// Purpose: Two-wire link between the host and the configuration slave
// Assumes: Open-drain data line with pull-up; host alone drives the clock
// Notes: Output enables are low while a party pulls the line low
interface scfg_if;
    logic scl;
    logic sda_h_o;
    logic sda_h_oe_n;
    logic sda_d_o;
    logic sda_d_oe_n;
    logic sda;
    // Wired-and of the open-drain drivers
    assign sda = !((!sda_h_oe_n && !sda_h_o) || (!sda_d_oe_n && !sda_d_o));
    modport host (output scl, output sda_h_o, output sda_h_oe_n,
        input sda);
    modport device (input scl, output sda_d_o, output sda_d_oe_n,
        input sda);
endinterface : scfg_if

// ==== verilog/scfg_slave.sv ====
// Purpose: Two-wire slave holding the clock buffer configuration bytes
// Assumes: Link clock and data sampled by the 125 MHz system clock
// Notes: Byte and block reads and writes, command bit 7 picks the kind
module scfg_slave
    import scfg_pkg::*;
#(
    parameter int NREG = SCFG_NREG
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    scfg_if.device link,
    output logic [7:0] out_enable_q,
    output logic [8*NREG-1:0] cfg_q
);
    typedef enum logic [2:0] {
        SCFG_IDLE = 3'b000,
        SCFG_RX = 3'b001,
        SCFG_ACK = 3'b011,
        SCFG_TX = 3'b010,
        SCFG_MACK = 3'b110
    } scfg_state_t;

    // =====================================================
    // Pin synchronisers
    logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else if (ce) begin
            scl_s1_q <= link.scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= link.sda;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end
    logic scl_rise, scl_fall, start_ev, stop_ev;
    assign scl_rise = scl_s2_q && !scl_s3_q;
    assign scl_fall = !scl_s2_q && scl_s3_q;
    assign start_ev = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
    assign stop_ev = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

    // =====================================================
    // Protocol engine
    scfg_state_t st_q, st_d;
    logic [7:0] sh_q, sh_d;
    logic [2:0] bit_q, bit_d;
    logic [2:0] phase_q, phase_d; // 0 addr,1 cmd,2 count,3 data
    logic rd_q, rd_d, block_q, block_d, cnt_sent_q, cnt_sent_d;
    logic [6:0] ptr_q, ptr_d;
    logic drive_q, drive_d;
    logic full_q, full_d;
    logic [7:0] regs_q [NREG];
    logic [7:0] regs_d [NREG];

    function automatic logic [7:0] rd_reg(input logic [6:0] idx,
        input logic [7:0] r [NREG]);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (idx == 7'(i)) begin
                v = r[i];
            end
        end
        return v;
    endfunction

    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        phase_d = phase_q;
        rd_d = rd_q;
        block_d = block_q;
        cnt_sent_d = cnt_sent_q;
        ptr_d = ptr_q;
        drive_d = drive_q;
        full_d = full_q;
        regs_d = regs_q;
        if (start_ev) begin
            // Repeated start also aborts any partial byte
            st_d = SCFG_RX;
            full_d = 1'b0;
            bit_d = 3'h0;
            phase_d = 3'h0;
            drive_d = 1'b0;
        end else if (stop_ev) begin
            // Completed bytes were already committed
            st_d = SCFG_IDLE;
            drive_d = 1'b0;
        end else begin
            case (st_q)
                SCFG_IDLE: begin
                    drive_d = 1'b0;
                end
                SCFG_RX: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_s2_q};
                        bit_d = bit_q + 3'h1;
                        full_d = bit_q == 3'h7;
                    end
                    // The fall right after a start carries no byte yet
                    if (scl_fall && full_q) begin
                        full_d = 1'b0;
                        st_d = SCFG_ACK;
                        drive_d = 1'b1;
                        case (phase_q)
                            3'h0: begin
                                rd_d = sh_q[0];
                                if (sh_q[7:1] != SCFG_ADDR7) begin
                                    st_d = SCFG_IDLE;
                                    drive_d = 1'b0;
                                end
                            end
                            3'h1: begin
                                block_d = !sh_q[SCFG_CMD_MODE_BIT];
                                ptr_d = sh_q[7] ? sh_q[6:0] : 7'h00;
                                cnt_sent_d = 1'b0;
                            end
                            3'h3: begin
                                for (int i = 0; i < NREG; i++) begin
                                    if (ptr_q == 7'(i)) begin
                                        regs_d[i] = sh_q;
                                    end
                                end
                                ptr_d = ptr_q + 7'h1;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                SCFG_ACK: begin
                    // Hold the acknowledge low through the ninth clock
                    if (scl_fall) begin
                        drive_d = 1'b0;
                        bit_d = 3'h0;
                        st_d = SCFG_RX;
                        case (phase_q)
                            3'h0: phase_d = rd_q ? 3'h3 : 3'h1;
                            3'h1: phase_d = block_q ? 3'h2 : 3'h3;
                            default: phase_d = 3'h3;
                        endcase
                        if (phase_q == 3'h0 && rd_q) begin
                            st_d = SCFG_TX;
                            if (block_q && !cnt_sent_q) begin
                                sh_d = 8'(NREG);
                                cnt_sent_d = 1'b1;
                            end else begin
                                sh_d = rd_reg(ptr_q, regs_q);
                                ptr_d = ptr_q + 7'h1;
                            end
                            drive_d = !sh_d[7];
                            bit_d = 3'h1;
                        end
                    end
                end
                SCFG_TX: begin
                    if (scl_fall) begin
                        if (bit_q == 3'h0) begin
                            drive_d = 1'b0;
                            st_d = SCFG_MACK;
                        end else begin
                            drive_d = !sh_q[3'h7 - bit_q];
                            bit_d = bit_q + 3'h1;
                        end
                    end
                end
                SCFG_MACK: begin
                    if (scl_rise) begin
                        // A host not-acknowledge ends the read
                        st_d = sda_s2_q ? SCFG_IDLE : SCFG_MACK;
                        bit_d = 3'h0;
                    end else if (scl_fall && (!block_q
                        || ptr_q >= 7'(NREG))) begin
                        st_d = SCFG_IDLE;
                    end else if (scl_fall) begin
                        st_d = SCFG_TX;
                        sh_d = rd_reg(ptr_q, regs_q);
                        ptr_d = ptr_q + 7'h1;
                        drive_d = !sh_d[7];
                        bit_d = 3'h1;
                    end
                end
                default: st_d = SCFG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= SCFG_IDLE;
            sh_q <= 8'h00;
            bit_q <= 3'h0;
            phase_q <= 3'h0;
            rd_q <= 1'b0;
            block_q <= 1'b0;
            cnt_sent_q <= 1'b0;
            ptr_q <= 7'h00;
            drive_q <= 1'b0;
            full_q <= 1'b0;
            regs_q[0] <= SCFG_DEF0;
            regs_q[1] <= SCFG_DEF1;
            for (int i = 2; i < NREG; i++) begin
                regs_q[i] <= SCFG_DEF2;
            end
        end else if (ce) begin
            st_q <= st_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            phase_q <= phase_d;
            rd_q <= rd_d;
            block_q <= block_d;
            cnt_sent_q <= cnt_sent_d;
            ptr_q <= ptr_d;
            drive_q <= drive_d;
            full_q <= full_d;
            regs_q <= regs_d;
        end
    end

    // =====================================================
    // Outputs
    logic oe_n_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            out_enable_q <= SCFG_DEF1;
            cfg_q <= '0;
            oe_n_q <= 1'b1;
        end else if (ce) begin
            oe_n_q <= !drive_q;
            out_enable_q <= regs_q[SCFG_OE_REG];
            for (int i = 0; i < NREG; i++) begin
                cfg_q[8*i +: 8] <= regs_q[i];
            end
        end
    end
    assign link.sda_d_o = 1'b0;
    assign link.sda_d_oe_n = oe_n_q;
endmodule : scfg_slave

// ==== verilog/scfg_host.sv ====
// Purpose: Host end issuing byte and block transfers to the slave
// Assumes: Host makes the link clock by dividing the system clock
// Notes: One request at a time; block count limited to 8 bytes
module scfg_host
    import scfg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    scfg_if.host link,
    input wire logic req,
    input wire logic req_rd,
    input wire logic req_block,
    input wire logic [6:0] req_off,
    input wire logic [3:0] req_len,
    input wire logic [63:0] req_wdata,
    output logic busy_q,
    output logic done_q,
    output logic nack_q,
    output logic [63:0] rdata_q
);
    typedef enum logic [1:0] {
        SCFGH_IDLE = 2'b00,
        SCFGH_RUN = 2'b01,
        SCFGH_END = 2'b11
    } scfgh_state_t;
    // Byte list: each entry {kind, byte}; kind 0 write,1 read,2 rstart
    scfgh_state_t st_q, st_d;
    logic [7:0] q_q [13];
    logic [7:0] q_d [13];
    logic [1:0] k_q [13];
    logic [1:0] k_d [13];
    logic [3:0] n_q, n_d, idx_q, idx_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] ph_q, ph_d;
    logic [4:0] tick_q, tick_d;
    logic scl_q, scl_d, sdo_q, sdo_d, busy_d, done_d, nack_d;
    logic [63:0] rd_d;
    logic sda_s1_q, sda_s2_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else if (ce) begin
            sda_s1_q <= link.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    // =====================================================
    // Sequencer: each bit is four quarter phases of the link clock
    always_comb begin
        st_d = st_q;
        q_d = q_q;
        k_d = k_q;
        n_d = n_q;
        idx_d = idx_q;
        bit_d = bit_q;
        ph_d = ph_q;
        tick_d = tick_q;
        scl_d = scl_q;
        sdo_d = sdo_q;
        busy_d = busy_q;
        done_d = 1'b0;
        nack_d = nack_q;
        rd_d = rdata_q;
        case (st_q)
            SCFGH_IDLE: begin
                if (req) begin
                    q_d[0] = SCFG_ADDR_BYTE;
                    k_d[0] = 2'h0;
                    q_d[1] = req_block ? SCFG_CMD_BLOCK : {1'b1, req_off};
                    k_d[1] = 2'h0;
                    for (int i = 2; i < 13; i++) begin
                        q_d[i] = 8'h00;
                        k_d[i] = 2'h1;
                    end
                    if (req_rd) begin
                        k_d[2] = 2'h2;
                        q_d[3] = SCFG_ADDR_BYTE | 8'h01;
                        k_d[3] = 2'h0;
                        // Count byte of a block read is one entry more
                        n_d = 4'h5 + (req_block ? req_len : 4'h0);
                    end else begin
                        if (req_block) begin
                            q_d[2] = {4'h0, req_len};
                            k_d[2] = 2'h0;
                        end
                        for (int i = 0; i < 8; i++) begin
                            q_d[i + (req_block ? 3 : 2)] = req_wdata[8*i +: 8];
                            k_d[i + (req_block ? 3 : 2)] = 2'h0;
                        end
                        n_d = (req_block ? 4'h3 + req_len : 4'h3);
                    end
                    idx_d = 4'h0;
                    bit_d = 4'h0;
                    ph_d = 2'h0;
                    tick_d = 5'h0;
                    sdo_d = 1'b0; // start
                    scl_d = 1'b1;
                    busy_d = 1'b1;
                    nack_d = 1'b0;
                    st_d = SCFGH_RUN;
                end
            end
            SCFGH_RUN: begin
                if (tick_q == 5'(SCFG_QTR_CYC - 1)) begin
                    tick_d = 5'h0;
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: scl_d = 1'b0;
                        2'h1: begin
                            if (k_q[idx_q] == 2'h2) begin
                                sdo_d = 1'b1;
                            end else if (bit_q < 4'h8) begin
                                sdo_d = k_q[idx_q] == 2'h1 ? 1'b1
                                    : q_q[idx_q][3'h7 - bit_q[2:0]];
                            end else begin
                                // Host acks all read bytes, last too
                                sdo_d = k_q[idx_q] != 2'h1;
                            end
                        end
                        2'h2: scl_d = 1'b1;
                        default: begin
                            if (k_q[idx_q] == 2'h2) begin
                                sdo_d = 1'b0; // repeated start
                                bit_d = 4'h0;
                                idx_d = idx_q + 4'h1;
                            end else if (bit_q < 4'h8) begin
                                bit_d = bit_q + 4'h1;
                                if (k_q[idx_q] == 2'h1) begin
                                    rd_d = {rdata_q[62:0], sda_s2_q};
                                end
                            end else begin
                                if (k_q[idx_q] == 2'h0 && sda_s2_q) begin
                                    nack_d = 1'b1;
                                end
                                bit_d = 4'h0;
                                idx_d = idx_q + 4'h1;
                                if (idx_q + 4'h1 == n_q || (k_q[idx_q]
                                    == 2'h0 && sda_s2_q)) begin
                                    st_d = SCFGH_END;
                                    ph_d = 2'h0;
                                end
                            end
                        end
                    endcase
                end else begin
                    tick_d = tick_q + 5'h1;
                end
            end
            SCFGH_END: begin
                if (tick_q == 5'(SCFG_QTR_CYC - 1)) begin
                    tick_d = 5'h0;
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: scl_d = 1'b0;
                        2'h1: sdo_d = 1'b0;
                        2'h2: scl_d = 1'b1;
                        default: begin
                            sdo_d = 1'b1; // stop
                            busy_d = 1'b0;
                            done_d = 1'b1;
                            st_d = SCFGH_IDLE;
                        end
                    endcase
                end else begin
                    tick_d = tick_q + 5'h1;
                end
            end
            default: st_d = SCFGH_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= SCFGH_IDLE;
            for (int i = 0; i < 13; i++) begin
                q_q[i] <= 8'h00;
                k_q[i] <= 2'h0;
            end
            n_q <= 4'h0;
            idx_q <= 4'h0;
            bit_q <= 4'h0;
            ph_q <= 2'h0;
            tick_q <= 5'h0;
            scl_q <= 1'b1;
            sdo_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            nack_q <= 1'b0;
            rdata_q <= 64'h0;
        end else if (ce) begin
            st_q <= st_d;
            q_q <= q_d;
            k_q <= k_d;
            n_q <= n_d;
            idx_q <= idx_d;
            bit_q <= bit_d;
            ph_q <= ph_d;
            tick_q <= tick_d;
            scl_q <= scl_d;
            sdo_q <= sdo_d;
            busy_q <= busy_d;
            done_q <= done_d;
            nack_q <= nack_d;
            rdata_q <= rd_d;
        end
    end
    assign link.scl = scl_q;
    assign link.sda_h_o = 1'b0;
    assign link.sda_h_oe_n = sdo_q;
endmodule : scfg_host

// ==== tb/scfg_checker.sv ====
// Purpose: Protocol checks on the link joining host and slave
// Assumes: One system clock; rst synchronous, active high
// Notes: Watches only the link where both ends are design code
module scfg_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_h_o,
    input wire logic sda_h_oe_n,
    input wire logic sda_d_o,
    input wire logic sda_d_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    wire dev_low = !sda_d_oe_n && !sda_d_o;
    wire host_low = !sda_h_oe_n && !sda_h_o;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ==========================================
    // Data line ownership
    a_dev_reset_idle: assert property (disable iff (1'b0)
        rst |=> !dev_low) else $error("device drives line in reset");
    a_dev_edge_low: assert property ($changed(dev_low) |-> !scl)
        else $error("device data moved while clock high");
    a_dev_low_bound: assert property (
        dev_low |-> ##[0:200] !dev_low)
        else $error("device holds data line too long");
    a_stop_quiet: assert property (
        scl && $rose(sda) |=> !dev_low [*4])
        else $error("device drives line after stop");
    a_host_yield: assert property (scl && dev_low |-> !host_low)
        else $error("host drives while device owns line");
    a_dev_yield: assert property (scl && host_low |-> !dev_low)
        else $error("device drives while host owns line");
    // ==========================================
    // Link clock framing
    a_scl_high_min: assert property ($rose(scl) |=> scl [*8])
        else $error("clock high phase too short");
    a_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
        else $error("clock low phase too short");
    a_start_clocks: assert property (
        scl && $fell(sda) |-> ##[1:40] !scl)
        else $error("no clock after start");
endmodule // scfg_checker

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the configuration link, both ends
// Assumes: ce tied high; second link driven bit by bit by the bench
// Notes: Second link breaks the protocol on purpose
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    n_errors++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_top
    import scfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0, req_rd = 1'b0, req_block = 1'b0;
    logic [6:0] req_off = '0;
    logic [3:0] req_len = '0;
    logic [63:0] req_wdata = '0;
    logic busy_q, done_q, nack_q;
    logic [63:0] rdata_q;
    logic [7:0] oe_a, oe_b;
    logic [23:0] cfg_a, cfg_b;
    int n_errors = 0;
    int n_tests = 0;
    scfg_if lk ();
    scfg_if lk2 ();
    scfg_host i_scfg_host (.clock(clock), .rst(rst), .ce(1'b1),
        .link(lk.host), .req(req), .req_rd(req_rd),
        .req_block(req_block), .req_off(req_off), .req_len(req_len),
        .req_wdata(req_wdata), .busy_q(busy_q), .done_q(done_q),
        .nack_q(nack_q), .rdata_q(rdata_q));
    scfg_slave i_scfg_slave (.clock(clock), .rst(rst), .ce(1'b1),
        .link(lk.device), .out_enable_q(oe_a), .cfg_q(cfg_a));
    scfg_slave i_scfg_slave_b (.clock(clock), .rst(rst), .ce(1'b1),
        .link(lk2.device), .out_enable_q(oe_b), .cfg_q(cfg_b));
    scfg_checker i_scfg_checker (.clock(clock), .rst(rst), .scl(lk.scl),
        .sda(lk.sda), .sda_h_o(lk.sda_h_o), .sda_h_oe_n(lk.sda_h_oe_n),
        .sda_d_o(lk.sda_d_o), .sda_d_oe_n(lk.sda_d_oe_n));
    initial begin
        forever #4 clock = ~clock;
    end
    // ==========================================
    // Host end requests
    task automatic xfer(input logic rd, blk, input logic [6:0] off,
        input logic [3:0] len, input logic [63:0] wd);
        int n = 0;
        @(posedge clock);
        req <= 1'b1;
        req_rd <= rd;
        req_block <= blk;
        req_off <= off;
        req_len <= len;
        req_wdata <= wd;
        @(posedge clock);
        req <= 1'b0;
        while (done_q !== 1'b1 && n < 20000) begin
            @(posedge clock);
            n++;
        end
        `CHK("done", 1'b1, done_q)
        `CHK("busy", 1'b0, busy_q)
    endtask
    // ==========================================
    // Bit-level driver for the second link
    task automatic bb(input logic b, output logic r);
        lk2.sda_h_oe_n <= b;
        repeat (5) @(posedge clock);
        lk2.scl <= 1'b1;
        repeat (10) @(posedge clock);
        r = lk2.sda;
        lk2.scl <= 1'b0;
        repeat (5) @(posedge clock);
    endtask
    // Start when stop is low, otherwise stop; stop leaves the clock high
    task automatic bb_cond(input logic stop);
        lk2.sda_h_oe_n <= !stop;
        repeat (5) @(posedge clock);
        lk2.scl <= 1'b1;
        repeat (10) @(posedge clock);
        lk2.sda_h_oe_n <= stop;
        repeat (10) @(posedge clock);
        lk2.scl <= stop;
        repeat (5) @(posedge clock);
    endtask
    // Sends nb bits MSB first; the answer bit only for a whole byte
    task automatic bb_byte(input logic [7:0] v, input int nb,
        output logic ack);
        logic r;
        ack = 1'b1;
        for (int i = 7; i > 7 - nb; i--)
            bb(v[i], r);
        if (nb == 8)
            bb(1'b1, ack);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset;
        @(negedge clock);
        `CHK("cfg", {SCFG_DEF2, SCFG_DEF1, SCFG_DEF0}, cfg_a)
        `CHK("oe", SCFG_DEF1, oe_a)
        `CHK("idle sda", 1'b1, lk.sda)
    endtask
    task automatic t_byte;
        logic [7:0] v;
        for (int i = 0; i < 3; i++) begin
            v = 8'h5A ^ 8'(i * 8'h31);
            xfer(1'b0, 1'b0, 7'(i), 4'h1, {56'h0, v});
            `CHK("bw nack", 1'b0, nack_q)
            `CHK("bw reg", v, cfg_a[8*i +: 8])
            xfer(1'b1, 1'b0, 7'(i), 4'h1, '0);
            `CHK("br data", v, rdata_q[7:0])
        end
        `CHK("all regs", 24'h386B5A, cfg_a)
        `CHK("oe", 8'h6B, oe_a)
        xfer(1'b1, 1'b0, 7'h05, 4'h1, '0);
        `CHK("rd past end", 8'h00, rdata_q[7:0])
    endtask
    task automatic t_block;
        xfer(1'b0, 1'b1, 7'h00, 4'h3, 64'hC3A581);
        `CHK("blk nack", 1'b0, nack_q)
        `CHK("blk wr", 24'hC3A581, cfg_a)
        `CHK("blk oe", 8'hA5, oe_a)
        xfer(1'b0, 1'b1, 7'h00, 4'h1, 64'h11);
        `CHK("part wr", 24'hC3A511, cfg_a)
        xfer(1'b1, 1'b1, 7'h00, 4'h3, '0);
        `CHK("blk rd", {8'(SCFG_NREG), 24'h11A5C3}, rdata_q[31:0])
        xfer(1'b1, 1'b1, 7'h00, 4'h1, '0);
        `CHK("part rd", {8'(SCFG_NREG), 8'h11}, rdata_q[15:0])
    endtask
    task automatic t_bad_addr;
        logic a;
        logic [7:0] bad [3] = '{8'hDE, 8'h5C, 8'hDA};
        foreach (bad[i]) begin
            bb_cond(1'b0);
            bb_byte(bad[i], 8, a);
            `CHK("foreign ack", 1'b1, a)
            bb_byte(8'h81, 8, a);
            `CHK("foreign cmd", 1'b1, a)
            bb_byte(8'h00, 8, a);
            bb_cond(1'b1);
        end
        `CHK("foreign wr", SCFG_DEF1, oe_b)
    endtask
    task automatic t_abort;
        logic a;
        bb_cond(1'b0);
        bb_byte(SCFG_ADDR_BYTE, 8, a);
        `CHK("own ack", 1'b0, a)
        bb_byte(8'h81, 8, a);
        bb_byte(8'h00, 4, a);
        bb_cond(1'b1);
        `CHK("stop mid byte", SCFG_DEF1, oe_b)
        bb_cond(1'b0);
        bb_byte(SCFG_ADDR_BYTE, 8, a);
        bb_byte(8'h81, 8, a);
        bb_byte(8'h00, 5, a);
        bb_cond(1'b0);
        bb_byte(SCFG_ADDR_BYTE, 8, a);
        bb_byte(8'h81, 8, a);
        bb_byte(8'h3C, 8, a);
        `CHK("recover ack", 1'b0, a)
        bb_cond(1'b1);
        `CHK("wr after abort", 8'h3C, oe_b)
    endtask
    task automatic end_sim;
        $display("Checks %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        lk2.scl = 1'b1;
        lk2.sda_h_o = 1'b0;
        lk2.sda_h_oe_n = 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset;
        t_byte;
        t_block;
        t_bad_addr;
        t_abort;
        end_sim;
    end
    initial begin
        repeat (80000) @(posedge clock);
        n_errors++;
        end_sim;
    end
endmodule // tb_top
